/* verilog/vis_irq_sleep_ctrl.sv */
// Vectored interrupt controller with sleep and wake-up control
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Lowest vector address wins among pending requests; reset, then source 0.
// - A source is taken only with its enable and global enable both set.
// - Vector select bit moves the vector table base to boot section start.
// - Boot-reset fuse moves the reset vector to boot section start.
// - Programmed lock bits suppress interrupts depending on program counter region.
// - Taking an interrupt clears global enable.
// - Setting global enable inside a handler allows nested interrupts.
// - Return from interrupt sets global enable.
// - Flag-type service vectors the core and clears that flag.
// - Writing one to a flag clears it; writing zero keeps it.
// - Flag events latch even while the source enable is clear.
// - Flags latched with global enable clear are served later by priority.
// - Level sources request only while their condition is present.
// - After return, one instruction runs before another interrupt is taken.
// - No status register save or restore on entry or return.
// - Clear-global-enable blocks any interrupt in that very cycle.
// - Mode 000 is idle: CPU and flash clocks off, any interrupt wakes.
// - Mode 001 gates I/O, CPU, flash clocks; limited wake sources.
// - Mode 010 stops all clocks; only external, address-match, timer-free sources wake.
// - Deep-sleep wake waits a start-up delay chosen by clock-source fuses.
// - Mode 011 is power-save: power-down plus timer two wake-up.
// - Enabled converter starts a conversion on entry to idle or noise-reduction.
module vis_irq_sleep_ctrl
  import vis_pkg::*;
#(
  parameter int unsigned SU_CYC0 = `VIS_SU_CYC(`VIS_SU_T0_NS),
  parameter int unsigned SU_CYC1 = `VIS_SU_CYC(`VIS_SU_T1_NS),
  parameter int unsigned SU_CYC2 = `VIS_SU_CYC(`VIS_SU_T2_NS),
  parameter int unsigned SU_CYC3 = `VIS_SU_CYC(`VIS_SU_T3_NS)
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [`VIS_NUM_SRC-1:0] src_event,
  input wire logic [`VIS_NUM_SRC-1:0] src_enable,
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic ext_irq_two,
  input wire logic flag_wr_strobe,
  input wire logic [`VIS_NUM_SRC-1:0] flag_wr_data,
  input wire logic sei_instr,
  input wire logic cli_instr,
  input wire logic return_from_isr_instr,
  input wire logic instr_retired,
  input wire logic sleep_instr,
  input wire logic [`VIS_PC_W-1:0] core_pc,
  input wire logic [2:0] sleep_mode_field,
  input wire logic vector_table_boot_select,
  input wire vis_fuse_t fuses,
  input wire logic adc_enabled,
  output logic irq_take,
  output logic [3:0] irq_index,
  output logic [`VIS_PC_W-1:0] irq_vector,
  output logic [`VIS_PC_W-1:0] reset_vector,
  output logic global_irq_enable,
  output logic [`VIS_NUM_SRC-1:0] flag_pending,
  output logic cpu_clk_en,
  output logic flash_clk_en,
  output logic io_clk_en,
  output logic osc_run,
  output logic asleep,
  output logic adc_start
);

  //////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Lowest index is the lowest vector address
  function automatic logic [3:0] first_set(
    input logic [`VIS_NUM_SRC-1:0] v
  );
    logic [3:0] r;
    r = 4'h0;
    for (int i = `VIS_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [`VIS_NUM_SRC-1:0] wake_mask(
    input logic [2:0] m
  );
    logic [`VIS_NUM_SRC-1:0] r;
    case (m)
      `VIS_SM_IDLE: r = '1;
      `VIS_SM_ADCNR: r = `VIS_WAKE_ADCNR;
      `VIS_SM_PDOWN: r = `VIS_WAKE_PDOWN;
      `VIS_SM_PSAVE: r = `VIS_WAKE_PSAVE;
      default: r = '0;
    endcase
    return r;
  endfunction

  function automatic logic is_deep(
    input logic [2:0] m
  );
    return (m == `VIS_SM_PDOWN) || (m == `VIS_SM_PSAVE);
  endfunction

  function automatic logic in_boot(
    input logic [`VIS_PC_W-1:0] a
  );
    return a >= `VIS_BOOT_START;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  vis_state_t s_q;
  vis_state_t s_d;
  logic [`VIS_NUM_SRC-1:0] raw;
  logic [`VIS_NUM_SRC-1:0] pend;
  logic [`VIS_NUM_SRC-1:0] req;
  logic [`VIS_NUM_SRC-1:0] wake_req;
  logic [`VIS_NUM_SRC-1:0] clr;
  logic [2:0] pin_rise;
  logic [3:0] pick;
  logic [`VIS_PC_W-1:0] vbase;
  logic gie_eff;
  logic lock_block;
  logic can_take;
  logic tmr_start;
  logic tmr_done;
  logic [`VIS_NUM_SRC-1:0] flag_nxt;
  logic [`VIS_PC_W-1:0] vec_off;
  // Which sources are level type; these never own a latched flag
  localparam logic [`VIS_NUM_SRC-1:0] LEVEL_SRC = `VIS_LEVEL_MASK;

  vis_wake_timer #(
    .CYC0(SU_CYC0),
    .CYC1(SU_CYC1),
    .CYC2(SU_CYC2),
    .CYC3(SU_CYC3)
  ) u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(tmr_start),
    .sel(fuses.clock_source_fuses),
    .done(tmr_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Per-source slices

  // Pins are edge detected only after the second sync stage; the third
  // stage holds the previous synced level for the edge test
  for (genvar p = 0; p < 3; p++) begin : g_pin_edge
    assign pin_rise[p] = s_q.pin_s2[p] & ~s_q.pin_s3[p];
  end

  for (genvar g = 0; g < `VIS_NUM_SRC; g++) begin : g_src
    if (g < 3) begin : g_pin
      assign raw[g] = src_event[g] | pin_rise[g];
    end else begin : g_core
      assign raw[g] = src_event[g];
    end
    // Level sources bypass the flags and vanish with their condition
    if (LEVEL_SRC[g]) begin : g_lvl
      assign pend[g] = raw[g];
      assign flag_nxt[g] = 1'b0;
    end else begin : g_flg
      assign pend[g] = s_q.flag[g];
      // An event in the same cycle as a clear keeps the flag set
      assign flag_nxt[g] = (s_q.flag[g] & ~clr[g]) | raw[g];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request evaluation

  always_comb begin
    // A same-cycle clear-enable instruction already blocks acceptance
    gie_eff = s_q.gie & ~cli_instr;
    req = pend & src_enable & {`VIS_NUM_SRC{gie_eff}};
    // With that section's lock bit set, executing in the section that does not own the table is fenced off
    // A fenced request is held, not dropped: it is taken once the core
    // moves back into the section that owns the table
    lock_block = 1'b0;
    if (fuses.app_section_lock_bit && !in_boot(core_pc) && vector_table_boot_select) begin
      lock_block = 1'b1;
    end
    if (fuses.boot_section_lock_bit && in_boot(core_pc) && !vector_table_boot_select) begin
      lock_block = 1'b1;
    end
    can_take = (|req) && !s_q.hold_one && !lock_block && !s_q.take
      && (s_q.phase == VIS_RUN);
    pick = first_set(req);
    vbase = vector_table_boot_select ? `VIS_BOOT_START : `VIS_APP_START;
    wake_req = pend & src_enable & wake_mask(s_q.mode);
    // Each slot is two words and slot zero belongs to reset
    vec_off = `VIS_VEC_STRIDE * (`VIS_PC_W'(pick) + `VIS_PC_W'(1));
    // Software write-one clear and the hardware clear on service
    clr = '0;
    if (flag_wr_strobe) begin
      clr = flag_wr_data;
    end
    if (can_take) begin
      clr[pick] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.take = 1'b0;
    s_d.adc_start = 1'b0;
    tmr_start = 1'b0;
    s_d.pin_s1 = {ext_irq_two, ext_irq_one, ext_irq_zero};
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;
    s_d.rvec = fuses.reset_vector_boot_fuse ? `VIS_BOOT_START : `VIS_APP_START;

    // Flags come from the per-source slices, where a set beats any clear
    s_d.flag = flag_nxt;

    // Global enable; the status word itself is never stacked here
    if (return_from_isr_instr) begin
      s_d.gie = 1'b1;
    end else if (sei_instr) begin
      s_d.gie = 1'b1;
    end
    if (cli_instr) begin
      s_d.gie = 1'b0;
    end

    // One instruction of the interrupted code must retire first
    if (return_from_isr_instr) begin
      s_d.hold_one = 1'b1;
    end else if (instr_retired) begin
      s_d.hold_one = 1'b0;
    end

    if (can_take) begin
      s_d.take = 1'b1;
      s_d.idx = pick;
      s_d.gie = 1'b0;
      s_d.vec = vbase + vec_off;
    end

    case (s_q.phase)
      VIS_RUN: begin
        // A pending take goes first; a sleep in that same cycle is dropped, not retried
        if (sleep_instr && !can_take && (sleep_mode_field[2] == 1'b0)) begin
          s_d.phase = VIS_SLEEP;
          s_d.mode = sleep_mode_field;
          if (!is_deep(sleep_mode_field) && adc_enabled) begin
            s_d.adc_start = 1'b1;
          end
        end
      end
      VIS_SLEEP: begin
        // Pins wake through their latched flags, so a pin need not still be high here
        if (|wake_req) begin
          if (is_deep(s_q.mode)) begin
            s_d.phase = VIS_WAKE;
            tmr_start = 1'b1;
          end else begin
            s_d.phase = VIS_RUN;
          end
        end
      end
      VIS_WAKE: begin
        // Oscillator settles before the core sees the pending request
        if (tmr_done) begin
          s_d.phase = VIS_RUN;
        end
      end
      default: begin
        s_d.phase = VIS_RUN;
      end
    endcase

    // Clock gating follows the phase that is about to begin
    s_d.cpu_en = (s_d.phase == VIS_RUN);
    s_d.io_en = (s_d.phase == VIS_RUN) || (s_d.mode == `VIS_SM_IDLE);
    s_d.osc_en = (s_d.phase != VIS_SLEEP) || !is_deep(s_d.mode);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '{
        flag: '0,
        gie: 1'b0,
        hold_one: 1'b0,
        phase: VIS_RUN,
        mode: `VIS_SM_IDLE,
        pin_s1: 3'h0,
        pin_s2: 3'h0,
        pin_s3: 3'h0,
        take: 1'b0,
        idx: 4'h0,
        vec: '0,
        rvec: '0,
        adc_start: 1'b0,
        cpu_en: 1'b1,
        io_en: 1'b1,
        osc_en: 1'b1
      };
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign irq_take = s_q.take;
  assign irq_index = s_q.idx;
  assign irq_vector = s_q.vec;
  assign reset_vector = s_q.rvec;
  assign global_irq_enable = s_q.gie;
  assign flag_pending = s_q.flag;
  assign cpu_clk_en = s_q.cpu_en;
  // Flash only feeds the core, so it shares the core gate
  assign flash_clk_en = s_q.cpu_en;
  assign io_clk_en = s_q.io_en;
  assign osc_run = s_q.osc_en;
  assign asleep = (s_q.phase != VIS_RUN);
  assign adc_start = s_q.adc_start;

endmodule
`default_nettype wire

/* verilog/vis_consts.svh */
// Constants for the vectored interrupt and sleep controller
`ifndef VIS_CONSTS_SVH
`define VIS_CONSTS_SVH
`define VIS_NUM_SRC 16
`define VIS_PC_W 14
`define VIS_BOOT_START 14'h3800
`define VIS_APP_START 14'h0000
`define VIS_VEC_STRIDE 14'h0002
`define VIS_SM_IDLE 3'h0
`define VIS_SM_ADCNR 3'h1
`define VIS_SM_PDOWN 3'h2
`define VIS_SM_PSAVE 3'h3
`define VIS_LEVEL_MASK 16'h8000
`define VIS_WAKE_ADCNR 16'hE01F
`define VIS_WAKE_PDOWN 16'h2007
`define VIS_WAKE_PSAVE 16'h201F
`define VIS_CLK_PERIOD_NS 50
`define VIS_SU_T0_NS 1000
`define VIS_SU_T1_NS 100000
`define VIS_SU_T2_NS 4100000
`define VIS_SU_T3_NS 65000000
`define VIS_SU_CYC(t) (((t) + `VIS_CLK_PERIOD_NS - 1) / `VIS_CLK_PERIOD_NS)
`define VIS_TMR_W 21
`endif

/* verilog/vis_pkg.sv */
// Types shared by the interrupt and sleep controller modules
`include "vis_consts.svh"
package vis_pkg;
  typedef enum logic [1:0] {VIS_RUN, VIS_SLEEP, VIS_WAKE} vis_phase_t;
  typedef struct packed {
    logic reset_vector_boot_fuse;
    logic app_section_lock_bit;
    logic boot_section_lock_bit;
    logic [1:0] clock_source_fuses;
  } vis_fuse_t;
  typedef struct packed {
    logic [`VIS_NUM_SRC-1:0] flag;
    logic gie;
    logic hold_one;
    vis_phase_t phase;
    logic [2:0] mode;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic take;
    logic [3:0] idx;
    logic [`VIS_PC_W-1:0] vec;
    logic [`VIS_PC_W-1:0] rvec;
    logic adc_start;
    logic cpu_en;
    logic io_en;
    logic osc_en;
  } vis_state_t;
  typedef struct packed {
    logic busy;
    logic done;
    logic [`VIS_TMR_W-1:0] cnt;
  } vis_tmr_t;
endpackage

/* verilog/vis_wake_timer.sv */
// Start-up delay counter run after a deep-sleep wake-up
`timescale 1ns/1ps
`default_nettype none
module vis_wake_timer
  import vis_pkg::*;
#(
  parameter int unsigned CYC0 = 1,
  parameter int unsigned CYC1 = 1,
  parameter int unsigned CYC2 = 1,
  parameter int unsigned CYC3 = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [1:0] sel,
  output logic done
);
  vis_tmr_t t_q;
  vis_tmr_t t_d;
  logic [`VIS_TMR_W-1:0] load;

  always_comb begin
    case (sel)
      2'h0: load = `VIS_TMR_W'(CYC0 - 1);
      2'h1: load = `VIS_TMR_W'(CYC1 - 1);
      2'h2: load = `VIS_TMR_W'(CYC2 - 1);
      default: load = `VIS_TMR_W'(CYC3 - 1);
    endcase
    t_d = t_q;
    t_d.done = 1'b0;
    if (start) begin
      t_d.busy = 1'b1;
      t_d.cnt = load;
    end else if (t_q.busy) begin
      if (t_q.cnt == '0) begin
        t_d.busy = 1'b0;
        t_d.done = 1'b1;
      end else begin
        t_d.cnt = t_q.cnt - `VIS_TMR_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign done = t_q.done;
endmodule
`default_nettype wire

/* tb/vis_irq_sleep_ctrl_asserts.sv */
// Port assertions for the interrupt and sleep controller
`timescale 1ns/1ps
`default_nettype none
module vis_chk
  import vis_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [15:0] src_event,
  input wire logic [15:0] src_enable,
  input wire logic flag_wr_strobe,
  input wire logic [15:0] flag_wr_data,
  input wire logic cli_instr,
  input wire logic return_from_isr_instr,
  input wire logic sleep_instr,
  input wire logic [2:0] sleep_mode_field,
  input wire logic vector_table_boot_select,
  input wire vis_fuse_t fuses,
  input wire logic adc_enabled,
  input wire logic irq_take,
  input wire logic [3:0] irq_index,
  input wire logic [13:0] irq_vector,
  input wire logic [13:0] reset_vector,
  input wire logic global_irq_enable,
  input wire logic [15:0] flag_pending,
  input wire logic cpu_clk_en,
  input wire logic io_clk_en,
  input wire logic osc_run,
  input wire logic asleep,
  input wire logic adc_start
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Sleep entry from a quiet, awake core with nothing to take
  sequence s_slp;
    sleep_instr && !sleep_mode_field[2] && !asleep && !irq_take &&
      !(global_irq_enable && !cli_instr &&
      |(src_enable & (flag_pending | (src_event & 16'h8000))));
  endsequence
  a_take_clr_gie: assert property (irq_take |-> !global_irq_enable)
    else $error("take left global enable set");
  a_take_needs_en: assert property (irq_take |-> $past(global_irq_enable) &&
    ($past(src_enable) & (16'h0001 << irq_index)) != 16'h0000)
    else $error("take without enables");
  a_vec_base: assert property (irq_take |-> irq_vector ==
    ($past(vector_table_boot_select) ? 14'h3800 : 14'h0000) + 14'(irq_index) * 14'h0002 + 14'h0002)
    else $error("wrong vector");
  a_rst_vec: assert property (!$past(sys_rst) |->
    reset_vector == ($past(fuses.reset_vector_boot_fuse) ? 14'h3800 : 14'h0000))
    else $error("wrong reset vector");
  a_cli_blocks: assert property (cli_instr |=> !irq_take && !global_irq_enable)
    else $error("take after clear");
  a_ret_sets: assert property (return_from_isr_instr && !cli_instr && !global_irq_enable
    |=> global_irq_enable)
    else $error("return left enable clear");
  a_ret_hold: assert property (return_from_isr_instr && !global_irq_enable
    |=> !irq_take [*2])
    else $error("take too soon after return");
  a_sleep_gate: assert property (s_slp |=> asleep && !cpu_clk_en &&
    io_clk_en == ($past(sleep_mode_field) == 3'h0) && osc_run == !$past(sleep_mode_field[1]))
    else $error("wrong clock gating in sleep");
  a_adc_entry: assert property (s_slp |=>
    adc_start == ($past(adc_enabled) && !$past(sleep_mode_field[1])))
    else $error("wrong conversion start");
  a_flag_clr: assert property (flag_wr_strobe |=>
    (flag_pending & $past(flag_wr_data & ~src_event)) == 16'h0000)
    else $error("written flag not cleared");
  c_boot_take: cover property (irq_take && vector_table_boot_select);
  c_wake: cover property (asleep ##1 !asleep);
  c_cli_pend: cover property (cli_instr ##1 flag_pending != 16'h0000);
endmodule
bind vis_irq_sleep_ctrl vis_chk vis_chk_inst (.core_clk, .sys_rst, .src_event, .src_enable,
  .flag_wr_strobe, .flag_wr_data, .cli_instr, .return_from_isr_instr, .sleep_instr,
  .sleep_mode_field, .vector_table_boot_select, .fuses, .adc_enabled, .irq_take, .irq_index,
  .irq_vector, .reset_vector, .global_irq_enable, .flag_pending, .cpu_clk_en, .io_clk_en,
  .osc_run, .asleep, .adc_start);
`default_nettype wire

/* tb/vis_core_model.sv */
// Core sequencing model: retires instructions and returns from handlers
`timescale 1ns/1ps
`default_nettype none
module vis_core_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic irq_take,
  input wire logic cpu_clk_en,
  input wire logic [3:0] ret_dly,
  output logic return_from_isr_instr,
  output logic instr_retired
);
  logic [3:0] cnt_q;
  // A nested take restarts the count, so only the innermost handler returns
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
    end else if (irq_take) begin
      cnt_q <= ret_dly;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
    return_from_isr_instr <= !sys_rst && !irq_take && cnt_q == 4'h1;
    instr_retired <= !sys_rst && cpu_clk_en && cnt_q != 4'h1;
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the interrupt and sleep controller
`timescale 1ns/1ps
`default_nettype none
module tb
  import vis_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] ev = 16'h0000, en = 16'h0000, wd = 16'h0000, mf = 16'h0000, fp;
  logic ws = 1'b0, x0 = 1'b0, x1 = 1'b0, x2 = 1'b0, sei = 1'b0, cli = 1'b0, slp = 1'b0;
  logic ivs = 1'b0, adc = 1'b0, tk, gie, asl, ce, fe, ie, osc, ads, ret, rtd;
  logic [13:0] pc = 14'h0000, vec, rv;
  logic [2:0] sm = 3'h0;
  logic [3:0] ix, rd = 4'h3;
  vis_fuse_t fz = 5'h00;
  int error_cnt = 0, n_tests = 0, ntk = 0, nwk = 0, n0, n1;
  int unsigned seed = 22601;
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (tk === 1'b1) ntk++;
  // Cycles spent asleep with the oscillator running: the whole sleep in modes 0 and 1, the start-up wait in the deep modes
  always @(posedge core_clk) if (asl === 1'b1 && osc === 1'b1) nwk++;
  vis_irq_sleep_ctrl #(.SU_CYC0(3), .SU_CYC1(5), .SU_CYC2(7), .SU_CYC3(9)) vis_irq_sleep_ctrl_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .src_event(ev), .src_enable(en),
    .ext_irq_zero(x0), .ext_irq_one(x1), .ext_irq_two(x2), .flag_wr_strobe(ws),
    .flag_wr_data(wd), .sei_instr(sei), .cli_instr(cli), .return_from_isr_instr(ret),
    .instr_retired(rtd), .sleep_instr(slp), .core_pc(pc), .sleep_mode_field(sm),
    .vector_table_boot_select(ivs), .fuses(fz), .adc_enabled(adc), .irq_take(tk),
    .irq_index(ix), .irq_vector(vec), .reset_vector(rv), .global_irq_enable(gie),
    .flag_pending(fp), .cpu_clk_en(ce), .flash_clk_en(fe), .io_clk_en(ie), .osc_run(osc),
    .asleep(asl), .adc_start(ads));
  vis_core_model vis_core_model_inst (.core_clk(core_clk), .sys_rst(sys_rst), .irq_take(tk),
    .cpu_clk_en(ce), .ret_dly(rd), .return_from_isr_instr(ret), .instr_retired(rtd));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic test_done();
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pl(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic pulse(input logic [15:0] m);
    ev = m;
    mf = mf | (m & 16'h7FFF);
    cyc(1);
    ev = 16'h0000;
  endtask
  // Waits for one take, then checks index, vector, enable and flags
  task automatic wt(input int i);
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while (tk !== 1'b1 && k < 60);
    chk(16'(i), tk === 1'b1 ? 16'(ix) : 16'hFFFF);
    chk((ivs ? 16'h3800 : 16'h0000) + 16'(2 * i + 2), 16'(vec));
    chk(16'h0000, 16'(gie));
    mf[i] = 1'b0;
    @(negedge core_clk);
    chk(mf, fp);
  endtask
  task automatic serve();
    int i;
    while (mf !== 16'h0000) begin
      i = 0;
      while (!mf[i]) i++;
      wt(i);
    end
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    cyc(12);
    sys_rst = 1'b0;
    adc = 1'b1;
    for (int p = 0; p < 2; p++) begin
      cyc(8); // Lets the last handler return before global enable is dropped
      pl(cli);
      ivs = p[0];
      fz.reset_vector_boot_fuse = p[0];
      en = 16'h0000;
      pulse(rnd() & 16'h7FF8);
      x2 = 1'b1;
      cyc(5); // Held until the pin is seen
      x2 = 1'b0;
      mf[2] = 1'b1;
      chk(mf, fp);
      chk(p[0] ? 16'h3800 : 16'h0000, 16'(rv));
      en = 16'h7FFF;
      cyc(3);
      chk(mf, fp);
      pl(sei);
      serve();
    end
    pl(cli);
    en = 16'h0000;
    pulse(rnd() & 16'h7FF8);
    wd = rnd() & 16'h7FFF;
    pl(ws);
    mf = mf & ~wd;
    chk(mf, fp);
    cyc(1);
    wd = 16'h7FFF;
    pl(ws);
    mf = 16'h0000;
    en = 16'h7FFF;
    pl(sei);
    pulse(16'h0020);
    pl(cli);
    cyc(4);
    chk(mf, fp);
    pl(sei);
    serve();
    cyc(6);
    en = 16'h0000;
    ev[15] = 1'b1;
    cyc(3);
    ev[15] = 1'b0;
    en = 16'hFFFF;
    n0 = ntk;
    cyc(4);
    chk(16'(n0), 16'(ntk));
    ev[15] = 1'b1;
    wt(15);
    ev[15] = 1'b0;
    cyc(6);
    fz.app_section_lock_bit = 1'b1;
    ivs = 1'b1;
    pc = 14'h0100;
    pulse(16'h0040);
    cyc(5);
    chk(mf, fp);
    pc = 14'h3800;
    serve();
    fz.app_section_lock_bit = 1'b0;
    rd = 4'hC;
    cyc(6);
    pulse(16'h0400);
    wt(10);
    pl(sei);
    pulse(16'h0010);
    wt(4);
    cyc(30);
    rd = 4'h3;
    en = 16'h2009;
    for (int m = 0; m < 4; m++) begin
      fz.clock_source_fuses = 2'(rnd());
      sm = 3'(m);
      cyc(8);
      pl(slp);
      chk(16'({3'b100, m == 0, m < 2}), 16'({asl, ce, fe, ie, osc}));
      chk(16'(m < 2), 16'(ads));
      n1 = nwk;
      pulse(16'h0008);
      if (m == 2) begin
        cyc(15);
        chk(16'h0001, 16'(asl));
        x0 = 1'b1;
        cyc(6);
        x0 = 1'b0;
        mf[0] = 1'b1;
      end
      serve();
      // Start-up wait of 3, 5, 7 or 9 cycles plus the cycle that hands back to run
      if (m > 1) chk(16'(2 * fz.clock_source_fuses + 4), 16'(nwk - n1));
    end
    test_done();
  end
endmodule
`default_nettype wire
